/* File: shared/dpr_pkg.sv */
package dpr_pkg;
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_HOLE = 5'h05;
  localparam logic [4:0] ADDR_LAST = 5'h10;
  localparam logic [4:0] ADDR_PROF5 = 5'h0E;
  localparam logic [4:0] ADDR_PROF6 = 5'h0F;
  localparam logic [4:0] ADDR_PROF7 = 5'h10;
  localparam int PROF_FIRST = 5;
  localparam int PROF_COUNT = 3;
  localparam int PROF_BITS = 48;
  localparam int FTW_LSB = 0;
  localparam int FTW_BITS = 32;
  localparam int POW_LSB = 32;
  localparam int POW_BITS = 14;
  localparam logic [47:0] PROF_WRITABLE = 48'h3FFF_FFFF_FFFF;
  localparam logic [47:0] PROF_RESET = 48'h0000_0000_0000;
  localparam logic [31:0] CTRL1_RESET = 32'h0000_0000;
  localparam int CTRL1_INT_PROF_BIT = 27;
  localparam int CTRL1_PROF_SEL_MSB = 22;
  localparam int CTRL1_PROF_SEL_LSB = 20;
  localparam logic [3:0] LEN_CTRL1 = 4'h4;
  localparam logic [3:0] LEN_PROF = 4'h6;
  localparam logic [3:0] LEN_OTHER = 4'h4;
  localparam logic [3:0] LEN_NONE = 4'h0;

  // Byte count per serial address; zero marks the hole and anything past the map.
  function automatic logic [3:0] dpr_reg_len(input logic [4:0] addr);
    if (addr == ADDR_HOLE || addr > ADDR_LAST) begin
      return LEN_NONE;
    end else if (addr == ADDR_CTRL1) begin
      return LEN_CTRL1;
    end else if (addr >= 5'h09) begin
      return LEN_PROF;
    end else begin
      return LEN_OTHER;
    end
  endfunction : dpr_reg_len

  function automatic logic [7:0] dpr_pick_byte(input logic [47:0] word, input logic [2:0] idx);
    return word[{idx, 3'b000} +: 8];
  endfunction : dpr_pick_byte
endpackage : dpr_pkg

/* File: hdl/dpr_profile_bank.sv */
`timescale 1ns/10ps
// Function
// - Decode serial addresses 0x00 to 0x10; 0x05 is an unused hole.
// - Each register has only the bytes it needs; lengths differ by address.
// - Profile registers are 48 bits; 47:46 unused, 45:32 hold phase offset.
// - Written bits wait in a buffer until the transfer strobe moves them active.
// - Immediate bits act once their byte write completes, no strobe needed.
// - Bit 0 is the least significant; field A:B runs from A down to B.
// - Profiles 5 to 7 reset to zero in every byte.
// - Internal-profile bit selects profile from control bits, else from profile pins.
module dpr_profile_bank import dpr_pkg::*; #(
  parameter logic [31:0] CTRL1_IMMEDIATE = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic io_update,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [4:0] reg_addr,
  input wire logic [2:0] byte_idx,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] profile_pins,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic addr_err,
  output logic [2:0] active_profile,
  output logic active_hit,
  output logic [31:0] active_ftw,
  output logic [13:0] active_pow
);
  logic [31:0] ctrl1_buf;
  logic [31:0] ctrl1_act;
  logic [PROF_BITS-1:0] prof_buf [PROF_COUNT];
  logic [PROF_BITS-1:0] prof_act [PROF_COUNT];
  logic access;
  logic in_range;
  logic is_ctrl1;
  logic is_prof;
  logic [1:0] prof_slot;
  logic [2:0] next_profile;
  logic [4:0] slot_addr;

  assign access = ce && (wr_en || rd_en);
  assign in_range = {1'b0, byte_idx} < dpr_reg_len(reg_addr);
  assign is_ctrl1 = reg_addr == ADDR_CTRL1;
  assign is_prof = reg_addr >= ADDR_PROF5 && reg_addr <= ADDR_PROF7;
  assign slot_addr = reg_addr - ADDR_PROF5;
  assign prof_slot = slot_addr[1:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1_buf <= CTRL1_RESET;
    end else if (ce && wr_en && in_range && is_ctrl1) begin
      ctrl1_buf[{byte_idx[1:0], 3'b000} +: 8] <= wr_data;
    end
  end

  // Immediate bits follow the buffer on the next enabled clock; the others wait for the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1_act <= CTRL1_RESET;
    end else if (ce) begin
      ctrl1_act <= (io_update ? ctrl1_buf : ctrl1_act) & ~CTRL1_IMMEDIATE
        | (ctrl1_buf & CTRL1_IMMEDIATE);
    end
  end

  // Bits 47:46 are masked on write so they can never leave their default.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PROF_COUNT; i++) begin
        prof_buf[i] <= PROF_RESET;
      end
    end else if (ce && wr_en && in_range && is_prof) begin
      prof_buf[prof_slot][{byte_idx, 3'b000} +: 8] <= wr_data
        & PROF_WRITABLE[{byte_idx, 3'b000} +: 8];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PROF_COUNT; i++) begin
        prof_act[i] <= PROF_RESET;
      end
    end else if (ce && io_update) begin
      for (int i = 0; i < PROF_COUNT; i++) begin
        prof_act[i] <= prof_buf[i];
      end
    end
  end

  // Registers outside this bank decode but hold no storage here, so they read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      addr_err <= 1'b0;
    end else if (ce) begin
      rd_valid <= rd_en && in_range;
      addr_err <= access && !in_range;
      if (rd_en) begin
        if (in_range && is_ctrl1) begin
          rd_data <= dpr_pick_byte({16'h0000, ctrl1_buf}, byte_idx);
        end else if (in_range && is_prof) begin
          rd_data <= dpr_pick_byte(prof_buf[prof_slot], byte_idx);
        end else begin
          rd_data <= 8'h00;
        end
      end
    end
  end

  always_comb begin
    if (ctrl1_act[CTRL1_INT_PROF_BIT]) begin
      next_profile = ctrl1_act[CTRL1_PROF_SEL_MSB:CTRL1_PROF_SEL_LSB];
    end else begin
      next_profile = profile_pins;
    end
  end

  // Only profiles 5 to 7 live here; other selections report a miss and zero words.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_profile <= 3'h0;
      active_hit <= 1'b0;
      active_ftw <= 32'h0000_0000;
      active_pow <= 14'h0000;
    end else if (ce) begin
      active_profile <= next_profile;
      active_hit <= next_profile >= 3'(PROF_FIRST);
      if (next_profile >= 3'(PROF_FIRST)) begin
        active_ftw <= prof_act[2'(next_profile - 3'(PROF_FIRST))][FTW_LSB +: FTW_BITS];
        active_pow <= prof_act[2'(next_profile - 3'(PROF_FIRST))][POW_LSB +: POW_BITS];
      end else begin
        active_ftw <= 32'h0000_0000;
        active_pow <= 14'h0000;
      end
    end
  end

  property p_hole_reads_zero;
    @(posedge clk) disable iff (rst)
    (ce && rd_en && reg_addr == ADDR_HOLE) |=> (rd_data == 8'h00 && addr_err && !rd_valid);
  endproperty
  a_hole_reads_zero: assert property (p_hole_reads_zero) else $error("hole read not zero");

  property p_past_map_error;
    @(posedge clk) disable iff (rst)
    (ce && (wr_en || rd_en) && reg_addr > ADDR_LAST) |=> addr_err;
  endproperty
  a_past_map_error: assert property (p_past_map_error) else $error("unmapped access unflagged");

  property p_prof_length;
    @(posedge clk) disable iff (rst)
    (ce && rd_en && is_prof) |=> (rd_valid == ($past(byte_idx) < 3'h6));
  endproperty
  a_prof_length: assert property (p_prof_length) else $error("profile length wrong");

  property p_open_bits_zero;
    @(posedge clk) disable iff (rst)
    prof_buf[0][47:46] == 2'b00 && prof_buf[1][47:46] == 2'b00 && prof_buf[2][47:46] == 2'b00;
  endproperty
  a_open_bits_zero: assert property (p_open_bits_zero) else $error("open bits changed");

  property p_hold_without_strobe;
    @(posedge clk) disable iff (rst)
    !io_update |=> $stable(prof_act[0]) && $stable(prof_act[1]) && $stable(prof_act[2]);
  endproperty
  a_hold_without_strobe: assert property (p_hold_without_strobe) else $error("active moved");

  property p_strobe_transfers;
    @(posedge clk) disable iff (rst)
    (ce && io_update) |=> prof_act[2] == $past(prof_buf[2]) && ctrl1_act == $past(ctrl1_buf);
  endproperty
  a_strobe_transfers: assert property (p_strobe_transfers) else $error("strobe lost data");

  property p_immediate_bits;
    @(posedge clk) disable iff (rst)
    ce |=> (ctrl1_act & CTRL1_IMMEDIATE) == ($past(ctrl1_buf) & CTRL1_IMMEDIATE);
  endproperty
  a_immediate_bits: assert property (p_immediate_bits) else $error("immediate bit late");

  property p_byte_lane;
    @(posedge clk) disable iff (rst)
    (ce && wr_en && reg_addr == ADDR_PROF5 && byte_idx == 3'h0) |=>
      prof_buf[0][7:0] == $past(wr_data);
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte lane wrong");

  property p_reset_zero;
    @(posedge clk) rst |-> prof_act[0] == 48'h0 && prof_buf[2] == 48'h0;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("profile not reset");

  property p_profile_select;
    @(posedge clk) disable iff (rst)
    (ce && ctrl1_act[CTRL1_INT_PROF_BIT]) |=>
      active_profile == $past(ctrl1_act[CTRL1_PROF_SEL_MSB:CTRL1_PROF_SEL_LSB]);
  endproperty
  a_profile_select: assert property (p_profile_select) else $error("profile select wrong");

  c_strobe: cover property (@(posedge clk) disable iff (rst) ce && io_update && is_prof);
  c_hole: cover property (@(posedge clk) disable iff (rst) ce && wr_en && reg_addr == ADDR_HOLE);
  c_hit: cover property (@(posedge clk) disable iff (rst) active_hit && active_ftw != 32'h0);
endmodule : dpr_profile_bank

/* File: verification/dpr_host_model.sv */
`timescale 1ns/10ps
// Host side of the register port; it changes lines only on the falling edge.
module dpr_host_model (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic io_update,
  output logic [4:0] reg_addr,
  output logic [2:0] byte_idx,
  output logic [7:0] wr_data
);
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    io_update = 1'b0;
    reg_addr = 5'h00;
    byte_idx = 3'h0;
    wr_data = 8'h00;
  end

  // One byte per cycle; the caller picks the register and byte index, so a register can be sent in part.
  task access(input logic w, input logic r, input logic [4:0] a, input logic [2:0] i,
              input logic [7:0] d);
    @(negedge clk);
    wr_en = w;
    rd_en = r;
    io_update = 1'b0;
    reg_addr = a;
    byte_idx = i;
    wr_data = d;
  endtask : access

  // Idle data toggles so a stale byte is never mistaken for a live one.
  task idle(input logic upd);
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = 1'b0;
    io_update = upd;
    wr_data = ~wr_data;
  endtask : idle
endmodule : dpr_host_model

/* File: verification/dpr_profile_bank_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module dpr_profile_bank_tb import dpr_pkg::*;;
  logic clk, rst, ce, io_update, wr_en, rd_en, rd_valid, addr_err, active_hit;
  logic [4:0] reg_addr;
  logic [2:0] byte_idx, profile_pins, active_profile;
  logic [7:0] wr_data, rd_data;
  logic [31:0] active_ftw;
  logic [13:0] active_pow;
  logic [8:0] expq[$];
  logic [47:0] prof[3];
  logic [4:0] ra;
  logic [2:0] ri;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h01561edc;

  // Bit 27 is immediate here so that the no-strobe path is exercised.
  dpr_profile_bank #(.CTRL1_IMMEDIATE(32'h0800_0000)) dpr_profile_bank_inst (.clk(clk),
    .rst(rst), .ce(ce), .io_update(io_update), .wr_en(wr_en), .rd_en(rd_en),
    .reg_addr(reg_addr), .byte_idx(byte_idx), .wr_data(wr_data), .profile_pins(profile_pins),
    .rd_data(rd_data), .rd_valid(rd_valid), .addr_err(addr_err), .active_profile(active_profile),
    .active_hit(active_hit), .active_ftw(active_ftw), .active_pow(active_pow));
  dpr_host_model host_inst (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .io_update(io_update),
    .reg_addr(reg_addr), .byte_idx(byte_idx), .wr_data(wr_data));

  task rd(input logic [4:0] a, input logic [2:0] i, input logic [8:0] e);
    expq.push_back(e);
    host_inst.access(1'b0, 1'b1, a, i, 8'h00);
  endtask : rd

  task wr(input logic [4:0] a, input logic [2:0] i, input logic [7:0] d, input logic err);
    if (err) expq.push_back(9'h100);
    host_inst.access(1'b1, 1'b0, a, i, d);
  endtask : wr

  task chk_active(input logic [2:0] p, input logic [47:0] v, input logic h);
    repeat (3) @(negedge clk);
    `CHK(active_profile, p)
    `CHK(active_hit, h)
    `CHK({active_pow, active_ftw}, {v[45:32], v[31:0]})
  endtask : chk_active

  task report_and_stop;
    if (expq.size() != 0) n_errors++;
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Results are matched in order; a missing or extra answer shows as a mismatch.
  always @(posedge clk) begin
    logic [8:0] e;
    #1;
    if (rst === 1'b0 && (rd_valid === 1'b1 || addr_err === 1'b1)) begin
      e = (expq.size() != 0) ? expq.pop_front() : 9'h1FF;
      `CHK({addr_err, rd_valid ? rd_data : 8'h00}, e)
    end
  end

  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    profile_pins = 3'h5;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 3; p++) begin
      for (int b = 0; b < 6; b++) rd(5'(ADDR_PROF5 + p), 3'(b), 9'h000);
      prof[p] = 48'({$random(seed), $random(seed)});
      for (int b = 0; b < 6; b++) wr(5'(ADDR_PROF5 + p), 3'(b), prof[p][8*b +: 8], 1'b0);
      prof[p] = prof[p] & PROF_WRITABLE;
      for (int b = 0; b < 6; b++) rd(5'(ADDR_PROF5 + p), 3'(b), {1'b0, prof[p][8*b +: 8]});
    end
    host_inst.idle(1'b0);
    chk_active(3'h5, 48'h0, 1'b1);
    host_inst.idle(1'b1);
    host_inst.idle(1'b0);
    for (int p = 0; p < 3; p++) begin
      profile_pins = 3'(5 + p);
      chk_active(3'(5 + p), prof[p], 1'b1);
    end
    profile_pins = 3'h3;
    chk_active(3'h3, 48'h0, 1'b0);
    wr(ADDR_HOLE, 3'h0, 8'hFF, 1'b1);
    rd(ADDR_HOLE, 3'h0, 9'h100);
    rd(5'h11, 3'h0, 9'h100);
    rd(ADDR_PROF7, 3'h6, 9'h100);
    rd(5'h01, 3'h4, 9'h100);
    rd(5'h01, 3'h3, 9'h000);
    wr(ADDR_CTRL1, 3'h2, 8'h60, 1'b0);
    rd(ADDR_CTRL1, 3'h2, 9'h060);
    host_inst.idle(1'b1);
    host_inst.idle(1'b0);
    chk_active(3'h3, 48'h0, 1'b0);
    // Pins go random here; once the internal select acts they must be ignored.
    profile_pins = 3'($random(seed));
    wr(ADDR_CTRL1, 3'h3, 8'h08, 1'b0);
    host_inst.idle(1'b0);
    chk_active(3'h6, prof[1], 1'b1);
    // With the clock enable low a write and a strobe must both be lost.
    ce = 1'b0;
    wr(ADDR_PROF6, 3'h0, ~prof[1][7:0], 1'b0);
    host_inst.idle(1'b1);
    host_inst.idle(1'b0);
    chk_active(3'h6, prof[1], 1'b1);
    ce = 1'b1;
    rd(ADDR_PROF6, 3'h0, {1'b0, prof[1][7:0]});
    for (int k = 0; k < 16; k++) begin
      ra = 5'(ADDR_PROF5 + 5'($unsigned($random(seed)) % 4));
      ri = 3'($random(seed));
      if (ra > ADDR_LAST || {1'b0, ri} >= LEN_PROF) rd(ra, ri, 9'h100);
      else rd(ra, ri, {1'b0, prof[ra - ADDR_PROF5][8*ri +: 8]});
    end
    host_inst.idle(1'b0);
    // A second reset in mid-run must clear buffers and active words alike.
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    profile_pins = 3'h7;
    chk_active(3'h7, 48'h0, 1'b1);
    rd(ADDR_PROF7, 3'h5, 9'h000);
    host_inst.idle(1'b0);
    repeat (4) @(negedge clk);
    report_and_stop();
  end
endmodule : dpr_profile_bank_tb
